// ### inc/rpc_pkg.sv
package rpc_pkg;
	localparam int ADDR_W = 8;
	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_MODE = 8'h08;
	localparam logic [7:0] OFF_RATIO_N = 8'h0c;
	localparam logic [7:0] OFF_SCALE_M = 8'h10;
	localparam logic [7:0] OFF_SCALE_C = 8'h14;
	localparam logic [7:0] OFF_MEMV = 8'h18;
	localparam logic [7:0] OFF_FILT_LO = 8'h1c;
	localparam logic [7:0] OFF_FILT_HI = 8'h20;
	localparam logic [7:0] OFF_STAT_LO = 8'h24;
	localparam logic [7:0] OFF_STAT_HI = 8'h28;
	localparam logic [7:0] OFF_CNT_LO = 8'h2c;
	localparam logic [7:0] OFF_CNT_HI = 8'h30;
	localparam logic [7:0] OFF_MEAN = 8'h34;
	localparam logic [7:0] OFF_VAR = 8'h38;
	localparam logic [7:0] OFF_STD = 8'h3c;
	localparam logic [7:0] OFF_RMS = 8'h40;
	localparam logic [7:0] OFF_LAST = 8'h44;
	localparam logic [7:0] OFF_CDOWN = 8'h48;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int CTRL_SCALE = 0;
	localparam int CTRL_STAT = 1;
	localparam int CTRL_RATIO = 2;
	localparam int CTRL_FILT = 3;
	localparam int CTRL_ACT = 4;
	localparam int CTRL_RDY = 5;
	localparam int CMD_ACT = 0;
	localparam int CMD_COMP = 1;
	localparam int CMD_INIT = 2;
	localparam int CMD_WCLR = 3;
	localparam int CMD_N_MEM = 4;
	localparam int CMD_M_MEM = 5;
	localparam int CMD_C_MEM = 6;
	localparam int CMD_RTOG = 7;
	localparam int CMD_FTOG = 8;
	localparam int MODE_RATIO = 0;
	localparam int MODE_DB = 2;
	localparam int MODE_FILT = 4;
	localparam int MODE_STWIN = 8;
	localparam int MODE_SEL = 12;
	// ---------------------------------------------
	// Reset values and limits
	// ---------------------------------------------
	localparam logic [2:0] RATIO_RST = 3'h0;
	localparam logic [59:0] FILT_N_RST = 60'h00a;
	localparam logic [59:0] STAT_N_RST = 60'h00a;
	localparam logic [59:0] CNT_MAX = 60'hde0b6b3a7640000;
	localparam logic [4:0] WIN_MAX = 5'h10;
	localparam logic [31:0] ONE_Q = 32'h0001_0000;
	localparam logic [31:0] DB_K = 32'h0006_0546;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		FILT_CONT = 2'h0,
		FILT_SIMPLE = 2'h1,
		FILT_WALK = 2'h2
	} rpc_filt_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RATIO = 6'h02,
		ST_FILT = 6'h04,
		ST_SCALE = 6'h08,
		ST_STAT = 6'h10,
		ST_OUT = 6'h20
	} rpc_state_t;
endpackage

// ### hdl/rpc_chain.sv
// Functional notes
// - Each reading passes enabled stages in fixed order, each using prior result.
// - Ratio modes x/ref, ref/x, x/N, N/x, each plain or in dB.
// - Initialise sets ratio mode back to plain main over reference.
// - Ratio constant N is written directly or loaded from memory value.
// - Ratio toggle switches stage on or off, mode unchanged.
// - Continuous averaging outputs cumulative mean for every reading.
// - Simple averaging outputs one mean per block of n, n up to 1E18.
// - Simple averaging shows countdown for single triggers, none when repeating.
// - Walking window averages last n readings, n clamped to 16.
// - Walking window hides output and counts down until first full; code gives no countdown when repeating.
// - Initialise gives walking window of 10; toggle enables the filter.
// - Scale output is input times m plus c.
// - Scale m and c may each be loaded from memory value.
// - Continuous statistics update and output on every reading.
// - Window statistics output after n samples, then clear accumulators.
// - Statistics output selects reading, count, mean, variance, deviation or rms.
// - All statistics except pass-through kept in readable result store.
// - Window statistics shows countdown of readings still required.
// - Activation shows ready and lights compute; compute deactivates.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
module rpc_chain #(
	parameter int CNT_W = 60
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [rpc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [rpc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Readings in
	input wire logic rd_valid,
	input wire logic signed [31:0] rd_main,
	input wire logic signed [31:0] rd_ref,
	input wire logic rd_repeat,
	output logic rd_ready,
	// Results out
	output logic res_valid,
	output logic signed [31:0] res_data,
	output logic cd_valid,
	output logic [CNT_W-1:0] cd_count,
	output logic prog_ready,
	output logic compute_ind
);
	import rpc_pkg::*;

	// ---------------------------------------------
	// Arithmetic, Q16.16 throughout
	// ---------------------------------------------
	function automatic logic signed [31:0] sat32(
		input logic signed [127:0] v);
		if (v > 128'sh7fffffff)
			sat32 = 32'sh7fffffff;
		else if (v < -128'sh80000000)
			sat32 = -32'sh80000000;
		else
			sat32 = v[31:0];
	endfunction

	function automatic logic signed [127:0] idiv(
		input logic signed [127:0] a, input logic [CNT_W-1:0] n);
		idiv = a / $signed(128'(n));
	endfunction

	function automatic logic signed [31:0] qdiv(
		input logic signed [31:0] a, input logic signed [31:0] b);
		// Zero divisor saturates rather than trapping
		if (b == 32'sh0)
			qdiv = 32'sh7fffffff;
		else
			qdiv = sat32(128'($signed({a, 16'h0}) / 48'(b)));
	endfunction

	function automatic logic signed [31:0] qdb(
		input logic signed [31:0] q);
		logic [31:0] sh;
		logic signed [63:0] lg;
		int p;
		p = 0;
		for (int i = 0; i < 32; i++)
			if (q[i])
				p = i;
		sh = q << (31 - p);
		// Log2 by leading one plus linear mantissa
		lg = 64'(p - 16) * 64'sh10000 + $signed({48'h0, sh[30:15]});
		if (q <= 32'sh0)
			qdb = -32'sh80000000;
		else
			qdb = sat32(128'((lg * $signed({32'h0, DB_K})) >>> 16));
	endfunction

	function automatic logic [31:0] qsqrt(input logic [63:0] v);
		logic [31:0] t;
		qsqrt = 32'h0;
		for (int i = 31; i >= 0; i--) begin
			t = qsqrt | (32'h1 << i);
			if ({32'h0, t} * {32'h0, t} <= v)
				qsqrt = t;
		end
	endfunction

	function automatic logic [CNT_W-1:0] clamp_cnt(
		input logic [CNT_W-1:0] n);
		if (n == '0)
			clamp_cnt = CNT_W'(1);
		else if (n > CNT_W'(CNT_MAX))
			clamp_cnt = CNT_W'(CNT_MAX);
		else
			clamp_cnt = n;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	rpc_state_t state;
	logic signed [31:0] sv, ref_l, ratio_n, scale_m, scale_c, mem_val;
	logic rep_l, drop, scale_en, stat_en, ratio_en, filt_en, stat_win;
	logic [2:0] ratio_mode, stat_sel;
	rpc_filt_t filt_mode;
	logic [CNT_W-1:0] filt_n, stat_n, bn, sn;
	logic aw_hold, w_hold, we, def_we, act, clr_all;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data, w_new, cmd, rd_mux;
	logic [3:0] w_strb;
	logic rd_err;
	logic signed [95:0] f_sum, w_sum, next_fsum, next_wsum;
	logic [CNT_W-1:0] f_cnt, next_fcnt, f_cd;
	logic signed [31:0] win [16];
	logic signed [31:0] old, next_favg, next_ratio, next_scale;
	logic [3:0] w_ptr;
	logic [4:0] w_fill, wn, fill1;
	logic f_emit;
	logic signed [95:0] s_sum, ssum1;
	logic [127:0] s_sq, sq1;
	logic signed [127:0] msq, var128;
	logic [CNT_W-1:0] s_cnt, sn1, r_cnt;
	logic signed [31:0] mean, var_q, r_mean, r_var, r_std, r_rms;
	logic signed [31:0] next_stat;
	logic [31:0] std_q, rms_q;
	logic st_emit;

	assign we = aw_hold && w_hold && !bvalid;
	assign w_new = merge(32'h0, w_data, w_strb);
	assign def_we = we && !compute_ind;
	assign cmd = (we && aw_addr == OFF_CMD) ? w_new : 32'h0;
	assign act = cmd[CMD_ACT] && !compute_ind;
	assign clr_all = cmd[CMD_INIT] || act;
	assign bn = clamp_cnt(filt_n);
	assign sn = clamp_cnt(stat_n);
	assign wn = (filt_n > CNT_W'(WIN_MAX)) ? WIN_MAX :
		((filt_n == '0) ? 5'h1 : filt_n[4:0]);

	// ---------------------------------------------
	// Bus slave
	// ---------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
				aw_hold <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
				w_hold <= 1'b1;
				wready <= 1'b0;
			end
			if (we) begin
				bvalid <= 1'b1;
				bresp <= (aw_addr <= OFF_CDOWN && aw_addr[1:0] == 2'h0) ?
					RESP_OKAY : RESP_SLVERR;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		rd_err = 1'b0;
		if (araddr == OFF_CTRL)
			rd_mux = {26'h0, prog_ready, compute_ind, filt_en, ratio_en,
				stat_en, scale_en};
		else if (araddr == OFF_MODE)
			rd_mux = {17'h0, stat_sel, 3'h0, stat_win, 2'h0, filt_mode,
				1'b0, ratio_mode};
		else if (araddr == OFF_RATIO_N)
			rd_mux = ratio_n;
		else if (araddr == OFF_SCALE_M)
			rd_mux = scale_m;
		else if (araddr == OFF_SCALE_C)
			rd_mux = scale_c;
		else if (araddr == OFF_MEMV)
			rd_mux = mem_val;
		else if (araddr == OFF_FILT_LO)
			rd_mux = filt_n[31:0];
		else if (araddr == OFF_FILT_HI)
			rd_mux = 32'(filt_n[CNT_W-1:32]);
		else if (araddr == OFF_STAT_LO)
			rd_mux = stat_n[31:0];
		else if (araddr == OFF_STAT_HI)
			rd_mux = 32'(stat_n[CNT_W-1:32]);
		else if (araddr == OFF_CNT_LO)
			rd_mux = r_cnt[31:0];
		else if (araddr == OFF_CNT_HI)
			rd_mux = 32'(r_cnt[CNT_W-1:32]);
		else if (araddr == OFF_MEAN)
			rd_mux = r_mean;
		else if (araddr == OFF_VAR)
			rd_mux = r_var;
		else if (araddr == OFF_STD)
			rd_mux = r_std;
		else if (araddr == OFF_RMS)
			rd_mux = r_rms;
		else if (araddr == OFF_LAST)
			rd_mux = res_data;
		else if (araddr == OFF_CDOWN)
			rd_mux = cd_count[31:0];
		else if (araddr != OFF_CMD)
			rd_err = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ---------------------------------------------
	// Configuration
	// ---------------------------------------------
	// Definitions are locked while a program runs; toggles are not
	always_ff @(posedge aclk) begin
		if (!aresetn || cmd[CMD_INIT]) begin
			ratio_mode <= RATIO_RST;
			filt_mode <= FILT_WALK;
			filt_n <= CNT_W'(FILT_N_RST);
			stat_n <= CNT_W'(STAT_N_RST);
			stat_win <= 1'b0;
			stat_sel <= 3'h0;
			ratio_n <= ONE_Q;
			scale_m <= ONE_Q;
			scale_c <= 32'sh0;
			scale_en <= 1'b0;
			stat_en <= 1'b0;
			ratio_en <= 1'b0;
			filt_en <= 1'b0;
			compute_ind <= 1'b0;
			prog_ready <= 1'b0;
			if (!aresetn)
				mem_val <= 32'sh0;
		end else begin
			if (cmd[CMD_RTOG])
				ratio_en <= !ratio_en;
			if (cmd[CMD_FTOG])
				filt_en <= !filt_en;
			if (act) begin
				compute_ind <= 1'b1;
				prog_ready <= 1'b1;
			end else if (cmd[CMD_COMP]) begin
				compute_ind <= 1'b0;
				prog_ready <= 1'b0;
			end else if (res_valid)
				prog_ready <= 1'b0;
			if (def_we && cmd[CMD_N_MEM])
				ratio_n <= mem_val;
			if (def_we && cmd[CMD_M_MEM])
				scale_m <= mem_val;
			if (def_we && cmd[CMD_C_MEM])
				scale_c <= mem_val;
			if (we && aw_addr == OFF_MEMV)
				mem_val <= merge(mem_val, w_data, w_strb);
			if (def_we && aw_addr == OFF_CTRL) begin
				scale_en <= w_new[CTRL_SCALE];
				stat_en <= w_new[CTRL_STAT];
			end
			if (def_we && aw_addr == OFF_MODE && w_strb == 4'hf) begin
				ratio_mode <= w_data[MODE_RATIO +: 3];
				filt_mode <= rpc_filt_t'(w_data[MODE_FILT +: 2]);
				stat_win <= w_data[MODE_STWIN];
				stat_sel <= w_data[MODE_SEL +: 3];
			end
			if (def_we && aw_addr == OFF_RATIO_N)
				ratio_n <= merge(ratio_n, w_data, w_strb);
			if (def_we && aw_addr == OFF_SCALE_M)
				scale_m <= merge(scale_m, w_data, w_strb);
			if (def_we && aw_addr == OFF_SCALE_C)
				scale_c <= merge(scale_c, w_data, w_strb);
			if (def_we && aw_addr == OFF_FILT_LO)
				filt_n[31:0] <= merge(filt_n[31:0], w_data, w_strb);
			if (def_we && aw_addr == OFF_FILT_HI)
				filt_n[CNT_W-1:32] <= w_new[CNT_W-33:0];
			if (def_we && aw_addr == OFF_STAT_LO)
				stat_n[31:0] <= merge(stat_n[31:0], w_data, w_strb);
			if (def_we && aw_addr == OFF_STAT_HI)
				stat_n[CNT_W-1:32] <= w_new[CNT_W-33:0];
		end
	end

	// ---------------------------------------------
	// Stage arithmetic
	// ---------------------------------------------
	always_comb begin
		case (ratio_mode[1:0])
		2'h0: next_ratio = qdiv(sv, ref_l);
		2'h1: next_ratio = qdiv(ref_l, sv);
		2'h2: next_ratio = qdiv(sv, ratio_n);
		default: next_ratio = qdiv(ratio_n, sv);
		endcase
		if (ratio_mode[MODE_DB])
			next_ratio = qdb(next_ratio);
		next_scale = sat32(128'((64'(sv) * 64'(scale_m)) >>> 16) +
			128'(scale_c));
	end

	always_comb begin
		next_fcnt = f_cnt + 1'b1;
		next_fsum = f_sum + 96'(sv);
		old = (w_fill == wn) ? win[w_ptr] : 32'sh0;
		next_wsum = w_sum - 96'(old) + 96'(sv);
		fill1 = (w_fill == wn) ? wn : w_fill + 5'h1;
		f_cd = '0;
		if (filt_mode == FILT_WALK) begin
			f_emit = (fill1 == wn);
			f_cd = CNT_W'(wn - fill1);
			next_favg = sat32(idiv(128'(next_wsum), CNT_W'(fill1)));
		end else if (filt_mode == FILT_SIMPLE) begin
			f_emit = (next_fcnt == bn);
			f_cd = bn - next_fcnt;
			next_favg = sat32(idiv(128'(next_fsum), next_fcnt));
		end else begin
			f_emit = 1'b1;
			next_favg = sat32(idiv(128'(next_fsum), next_fcnt));
		end
	end

	always_comb begin
		sn1 = s_cnt + 1'b1;
		ssum1 = s_sum + 96'(sv);
		sq1 = s_sq + 128'(64'(sv) * 64'(sv));
		mean = sat32(idiv(128'(ssum1), sn1));
		msq = idiv($signed(sq1), sn1);
		var128 = msq - 128'(64'(mean) * 64'(mean));
		if (var128 < 128'sh0)
			var128 = 128'sh0;
		var_q = sat32(var128 >>> 16);
		std_q = qsqrt(var128[63:0]);
		rms_q = qsqrt(msq[63:0]);
		st_emit = !stat_win || sn1 == sn;
		case (stat_sel)
		3'h1: next_stat = sat32($signed(128'(sn1)) <<< 16);
		3'h2: next_stat = mean;
		3'h3: next_stat = var_q;
		3'h4: next_stat = std_q;
		3'h5: next_stat = rms_q;
		default: next_stat = sv;
		endcase
	end

	// ---------------------------------------------
	// Filter and statistics accumulators
	// ---------------------------------------------
	always_ff @(posedge aclk) begin
		if (state == ST_FILT && filt_en && filt_mode == FILT_WALK)
			win[w_ptr] <= sv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clr_all || cmd[CMD_WCLR]) begin
			f_sum <= 96'sh0;
			f_cnt <= '0;
			w_sum <= 96'sh0;
			w_ptr <= 4'h0;
			w_fill <= 5'h0;
		end else if (state == ST_FILT && filt_en) begin
			if (filt_mode == FILT_WALK) begin
				w_sum <= next_wsum;
				w_fill <= fill1;
				w_ptr <= (w_ptr == 4'(wn - 5'h1)) ? 4'h0 : w_ptr + 4'h1;
			end else if (filt_mode == FILT_SIMPLE && f_emit) begin
				f_sum <= 96'sh0;
				f_cnt <= '0;
			end else begin
				f_sum <= next_fsum;
				f_cnt <= next_fcnt;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clr_all) begin
			s_sum <= 96'sh0;
			s_sq <= 128'h0;
			s_cnt <= '0;
			r_cnt <= '0;
			r_mean <= 32'sh0;
			r_var <= 32'sh0;
			r_std <= 32'sh0;
			r_rms <= 32'sh0;
		end else if (state == ST_STAT && stat_en) begin
			if (stat_win && st_emit) begin
				s_sum <= 96'sh0;
				s_sq <= 128'h0;
				s_cnt <= '0;
			end else begin
				s_sum <= ssum1;
				s_sq <= sq1;
				s_cnt <= sn1;
			end
			if (st_emit) begin
				r_cnt <= sn1;
				r_mean <= mean;
				r_var <= var_q;
				r_std <= std_q;
				r_rms <= rms_q;
			end
		end
	end

	// ---------------------------------------------
	// Chain sequencer
	// ---------------------------------------------
	// One reading in flight; rd_ready holds the source off meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			sv <= 32'sh0;
			ref_l <= 32'sh0;
			rep_l <= 1'b0;
			drop <= 1'b0;
			rd_ready <= 1'b1;
			res_valid <= 1'b0;
			res_data <= 32'sh0;
			cd_valid <= 1'b0;
			cd_count <= '0;
		end else begin
			res_valid <= 1'b0;
			cd_valid <= 1'b0;
			case (state)
			ST_IDLE: if (rd_valid && rd_ready) begin
				sv <= rd_main;
				ref_l <= rd_ref;
				rep_l <= rd_repeat;
				drop <= 1'b0;
				rd_ready <= 1'b0;
				state <= compute_ind ? ST_RATIO : ST_OUT;
			end
			ST_RATIO: begin
				if (ratio_en)
					sv <= next_ratio;
				state <= ST_FILT;
			end
			ST_FILT: begin
				state <= ST_SCALE;
				if (filt_en && f_emit)
					sv <= next_favg;
				else if (filt_en) begin
					drop <= 1'b1;
					state <= ST_OUT;
					if (!rep_l && filt_mode != FILT_CONT) begin
						cd_valid <= 1'b1;
						cd_count <= f_cd;
					end
				end
			end
			ST_SCALE: begin
				if (scale_en)
					sv <= next_scale;
				state <= ST_STAT;
			end
			ST_STAT: begin
				state <= ST_OUT;
				if (stat_en && st_emit)
					sv <= next_stat;
				else if (stat_en) begin
					drop <= 1'b1;
					cd_valid <= 1'b1;
					cd_count <= sn - sn1;
				end
			end
			ST_OUT: begin
				res_valid <= !drop;
				res_data <= sv;
				rd_ready <= 1'b1;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chain_order_a: assert property (state == ST_RATIO |=>
		state == ST_FILT ##1 state inside {ST_SCALE, ST_OUT})
		else $error("chain order broken");
	ratio_init_a: assert property (cmd[CMD_INIT] |=>
		ratio_mode == 3'h0 && !compute_ind)
		else $error("ratio mode not restored");
	toggle_mode_a: assert property (cmd[CMD_RTOG] && !cmd[CMD_INIT]
		|=> ratio_en != $past(ratio_en) && $stable(ratio_mode))
		else $error("ratio toggle misbehaved");
	win_clamp_a: assert property (w_fill <= WIN_MAX && wn <= 5'h10)
		else $error("window above sixteen");
	cd_excl_a: assert property (cd_valid |-> ##1 !res_valid)
		else $error("result with countdown");
	filt_init_a: assert property (cmd[CMD_INIT] |=>
		filt_mode == FILT_WALK && filt_n == CNT_W'(10))
		else $error("filter default wrong");
	stat_win_a: assert property (stat_win && compute_ind |->
		s_cnt < sn)
		else $error("stat window overrun");
	ready_ind_a: assert property (act |=> compute_ind && prog_ready)
		else $error("activation not shown");
	one_pass_a: assert property (rd_valid && rd_ready && compute_ind
		|=> !rd_ready ##[1:5] rd_ready)
		else $error("reading not completed in six");

	cov_avg_c: cover property (state == ST_FILT && filt_en ##[1:4]
		res_valid);
	cov_cd_c: cover property (cd_valid && filt_mode == FILT_WALK);
	cov_db_c: cover property (state == ST_RATIO && ratio_en &&
		ratio_mode[MODE_DB]);
	cov_stat_c: cover property (state == ST_STAT && stat_win && st_emit);
endmodule

// ### tb/rpc_src.sv
module rpc_src (
	// Clock and handshake
	input wire logic aclk,
	input wire logic rd_ready,
	// Reading
	output logic rd_valid,
	output logic signed [31:0] rd_main,
	output logic signed [31:0] rd_ref,
	output logic rd_repeat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rd_valid = 1'b0;
		rd_main = 32'h0;
		rd_ref = 32'h0;
		rd_repeat = 1'b0;
	end
	// Gap gives arbitrary trigger spacing
	task automatic send(input logic [31:0] x, input int gap, input bit rep);
		repeat (gap + 1) @(posedge aclk);
		rd_valid <= 1'b1;
		rd_main <= x;
		rd_ref <= 32'h0001_0000;
		rd_repeat <= rep;
		do @(posedge aclk); while (rd_ready !== 1'b1);
		rd_valid <= 1'b0;
		// Released lines show no stale value
		rd_main <= ~x;
		rd_ref <= 32'hfffe_ffff;
	endtask
endmodule

// ### tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rpc_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, got, x;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, gr;
	logic awready, wready, bvalid, arready, rvalid, rd_valid, rd_repeat;
	logic rd_ready, res_valid, cd_valid, prog_ready, compute_ind;
	logic signed [31:0] rd_main, rd_ref, res_data;
	logic [59:0] cd_count;
	logic [31:0] exp_q[$];
	int num_errors = 0, checks_done = 0, seed = 90665;
	int cd_seen = 0, n0;
	bit rep = 1'b0;
	rpc_chain #(.CNT_W(60)) DUT (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rd_valid(rd_valid), .rd_main(rd_main), .rd_ref(rd_ref),
		.rd_repeat(rd_repeat), .rd_ready(rd_ready),
		.res_valid(res_valid), .res_data(res_data), .cd_valid(cd_valid),
		.cd_count(cd_count), .prog_ready(prog_ready),
		.compute_ind(compute_ind));
	rpc_src SRC (.aclk(aclk), .rd_ready(rd_ready), .rd_valid(rd_valid),
		.rd_main(rd_main), .rd_ref(rd_ref), .rd_repeat(rd_repeat));
	initial forever #2.5 aclk = ~aclk;
	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		gr = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		got = rdata;
		gr = rresp;
	endtask
	// Config is refused while active, so stop first
	task automatic cfg(input logic [31:0] mode, input logic [31:0] ctrl);
		wr(OFF_CMD, 32'h2);
		wr(OFF_MODE, mode);
		wr(OFF_CTRL, ctrl);
		wr(OFF_CMD, 32'h1);
		check({30'h0, prog_ready, compute_ind}, 32'h3);
	endtask
	task automatic go(input logic [31:0] v, input bit emit, input logic [31:0] e);
		if (emit) exp_q.push_back(e);
		// Repeat triggers come at a fixed spacing
		SRC.send(v, rep ? 2 : $unsigned($random(seed)) % 4, rep);
	endtask
	task automatic fin(input string s);
		repeat (12) @(posedge aclk);
		check(exp_q.size(), 32'h0);
		$display("Done %s", s);
	endtask
	task automatic give_verdict();
		$display("Checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------
	// Monitor
	// ----------------
	always @(posedge aclk) begin
		if (res_valid === 1'b1)
			check(res_data, exp_q.size() ? exp_q.pop_front() : ~res_data);
		if (cd_valid === 1'b1)
			cd_seen++;
	end
	initial begin
		#100us;
		num_errors++;
		give_verdict();
	end
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_MODE);
		check(got, 32'h20);
		rd(OFF_FILT_LO);
		check(got, 32'ha);
		rd(8'h4c);
		check({30'h0, gr}, {30'h0, RESP_SLVERR});
		wr(8'h4c, 32'h0);
		check({30'h0, gr}, {30'h0, RESP_SLVERR});
		fin("reset");
		x = $random(seed);
		go(x, 1, x);
		fin("bypass");
		wr(OFF_RATIO_N, 32'h2_0000);
		wr(OFF_SCALE_M, 32'h2_0000);
		wr(OFF_SCALE_C, 32'h1_0000);
		// Ratio and filter move only by their toggles and by initialise
		wr(OFF_CMD, 32'h80);
		cfg(32'h2, 32'h1);
		go(32'h6_0000, 1, 32'h7_0000);
		fin("chain");
		wr(OFF_CMD, 32'h2);
		wr(OFF_MEMV, 32'h4_0000);
		wr(OFF_CMD, 32'h70);
		cfg(32'h3, 32'h1);
		go(32'h8_0000, 1, 32'h6_0000);
		fin("memory");
		wr(OFF_CMD, 32'h180);
		cfg(32'h0, 32'h0);
		go(32'h2_0000, 1, 32'h2_0000);
		go(32'h4_0000, 1, 32'h3_0000);
		fin("continuous");
		wr(OFF_CMD, 32'h2);
		wr(OFF_FILT_LO, 32'h2);
		cfg(32'h10, 32'h0);
		go(32'h2_0000, 0, 32'h0);
		repeat (8) @(posedge aclk);
		check(cd_count[31:0], 32'h1);
		go(32'h4_0000, 1, 32'h3_0000);
		go(32'h6_0000, 0, 32'h0);
		go(32'h8_0000, 1, 32'h7_0000);
		rep = 1'b1;
		n0 = cd_seen;
		go(32'h2_0000, 0, 32'h0);
		go(32'h4_0000, 1, 32'h3_0000);
		rep = 1'b0;
		fin("simple");
		check(cd_seen - n0, 32'h0);
		wr(OFF_CMD, 32'h100);
		cfg(32'h2000, 32'h2);
		go(32'h2_0000, 1, 32'h2_0000);
		go(32'h4_0000, 1, 32'h3_0000);
		fin("stats");
		rd(OFF_MEAN);
		check(got, 32'h3_0000);
		wr(OFF_CMD, 32'h2);
		check({31'h0, compute_ind}, 32'h0);
		wr(OFF_STAT_LO, 32'h2);
		cfg(32'h3100, 32'h2);
		n0 = cd_seen;
		go(32'h1_0000, 0, 32'h0);
		go(32'h7_0000, 1, 32'h9_0000);
		fin("window");
		rd(OFF_STD);
		check(got, 32'h3_0000);
		rd(OFF_RMS);
		check(got, 32'h5_0000);
		rd(OFF_CNT_LO);
		check(got, 32'h2);
		go(32'h2_0000, 0, 32'h0);
		go(32'h3_0000, 1, 32'h4000);
		fin("restart");
		check(cd_seen - n0, 32'h2);
		wr(OFF_CMD, 32'h4);
		rd(OFF_MODE);
		check(got, 32'h20);
		fin("init");
		wr(OFF_CMD, 32'h80);
		cfg(32'h6, 32'h0);
		go(32'h2_0000, 1, DB_K);
		fin("decibel");
		wr(OFF_CMD, 32'h182);
		wr(OFF_FILT_LO, 32'h14);
		cfg(32'h20, 32'h0);
		n0 = cd_seen;
		for (int i = 1; i <= 16; i++)
			go(32'(i) << 16, i == 16, 32'h8_8000);
		go(32'h11_0000, 1, 32'h9_8000);
		wr(OFF_CMD, 32'h8);
		go(32'h1_0000, 0, 32'h0);
		fin("walk");
		check(cd_seen - n0, 32'h10);
		give_verdict();
	end
endmodule
